// File: src/aicf_top.sv
// Input configuration, conversion sequencing and output coding with APB.
`timescale 1ns/1ps
module aicf_top (
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST_N,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic                  CONVERSION_START_PIN,
  input  wire logic signed [17:0]    RAW_DIFF,
  output logic      [2:0]            MUX_POS_CH,
  output logic      [2:0]            MUX_NEG_CH,
  output aicf_pkg::aicf_neg_t        MUX_NEG_SRC,
  output logic                       NEG_BIAS_MID,
  output logic                       FILTER_QUARTER_BW,
  output logic                       CONV_BUSY,
  output logic      [15:0]           RESULT_CODE
);
  import aicf_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  aicf_mux_if mux ();

  logic [13:0]        cfg_reg,    cfg_next;
  logic [31:0]        rdata_reg,  rdata_next;
  logic               s1_reg, s2_reg, s3_reg;
  logic               start_lvl_reg, start_lvl_next;
  aicf_state_t        state_reg,  state_next;
  logic [CNT_W-1:0]   cnt_reg,    cnt_next;
  logic [CNT_W-1:0]   gap_reg,    gap_next;
  logic               seen_reg,   seen_next;
  logic               bip_reg,    bip_next;
  logic signed [17:0] hold_reg,   hold_next;
  logic [15:0]        result_reg, result_next;
  logic               valid_reg,  valid_next;
  logic               rate_reg,   rate_next;
  logic [2:0]         pos_reg,    pos_next;
  logic [2:0]         neg_reg,    neg_next;
  aicf_neg_t          src_reg,    src_next;
  logic               mid_reg,    mid_next;
  logic               bw_reg,     bw_next;
  logic [15:0]        fmt_code;
  logic               setup, access, mapped, wr_cfg, rd_result, wr_status;
  logic               start_rise, done;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign setup     = PSEL && !PENABLE;
  assign access    = PSEL && PENABLE;
  assign mapped    = (PADDR == ADDR_CFG) || (PADDR == ADDR_RESULT) ||
                     (PADDR == ADDR_STATUS);
  assign wr_cfg    = access && PWRITE && (PADDR == ADDR_CFG);
  assign wr_status = access && PWRITE && (PADDR == ADDR_STATUS);
  assign rd_result = access && !PWRITE && (PADDR == ADDR_RESULT);
  assign PREADY    = 1'b1;
  assign PSLVERR   = access && !mapped;
  assign PRDATA    = rdata_reg;

  // ----------------------------------------------------------------------
  // Mode decode and output coding
  // ----------------------------------------------------------------------
  assign mux.incc   = cfg_reg[CFG_INCC_LSB +: 3];
  assign mux.inx    = cfg_reg[CFG_INX_LSB +: 3];
  assign mux.seq_on = cfg_reg[CFG_SEQ_LSB +: 2] != 2'b00;

  aicf_mode_decode u_dec (
    .m (mux.dec)
  );

  aicf_code_format u_fmt (
    .diff    (hold_reg),
    .bipolar (bip_reg),
    .code    (fmt_code)
  );

  // ----------------------------------------------------------------------
  // Start pin synchroniser
  // ----------------------------------------------------------------------
  // A pin change only counts once the second and third stages agree.
  assign start_lvl_next = (s2_reg == s3_reg) ? s3_reg : start_lvl_reg;
  assign start_rise     = s2_reg && s3_reg && !start_lvl_reg;
  assign done           = (state_reg == S_CONV) && (cnt_reg == '0);

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    cfg_next    = cfg_reg;
    rdata_next  = rdata_reg;
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    gap_next    = gap_reg;
    seen_next   = seen_reg;
    bip_next    = bip_reg;
    hold_next   = hold_reg;
    result_next = result_reg;
    pos_next    = pos_reg;
    neg_next    = neg_reg;
    src_next    = src_reg;
    mid_next    = mid_reg;
    bw_next     = cfg_reg[CFG_BW_BIT];
    rate_next   = rate_reg;
    // Set wins over clear for both sticky flags.
    valid_next  = done || (valid_reg && !rd_result);
    if (wr_status && PWDATA[STAT_RATE_ERR]) begin
      rate_next = 1'b0;
    end
    if (wr_cfg) begin
      cfg_next = PWDATA[CFG_W-1:0];
    end
    if (gap_reg != QBW_GAP_CYCLES[CNT_W-1:0]) begin
      gap_next = gap_reg + 1'b1;
    end
    if (setup) begin
      case (PADDR)
        ADDR_CFG:    rdata_next = {18'h0_0000, cfg_reg};
        ADDR_RESULT: rdata_next = {16'h0000, result_reg};
        ADDR_STATUS: rdata_next = {20'h0_0000, src_reg, neg_reg, pos_reg,
                                   rate_reg, bip_reg, valid_reg,
                                   state_reg == S_CONV};
        default:     rdata_next = 32'h0000_0000;
      endcase
    end
    case (state_reg)
      S_ACQ: begin
        // The mux follows the configuration only while acquiring.
        pos_next = mux.pos_ch;
        neg_next = mux.neg_ch;
        src_next = mux.neg_src;
        mid_next = mux.bipolar;
        if (start_rise) begin
          state_next = S_CONV;
          cnt_next   = CONV_CYCLES[CNT_W-1:0] - 1'b1;
          bip_next   = mux.bipolar;
          hold_next  = RAW_DIFF;
          gap_next   = '0;
          seen_next  = 1'b1;
          // Quarter bandwidth needs a start spacing four times longer.
          if (cfg_reg[CFG_BW_BIT] && seen_reg &&
              gap_reg < QBW_GAP_CYCLES[CNT_W-1:0]) begin
            rate_next = 1'b1;
          end
        end
      end
      S_CONV: begin
        // Starts during a conversion are ignored.
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0) begin
          state_next  = S_ACQ;
          cnt_next    = '0;
          result_next = fmt_code;
        end
      end
      default: state_next = S_ACQ;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    s1_reg <= CONVERSION_START_PIN;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    if (!RST_N) begin
      cfg_reg       <= CFG_RESET;
      rdata_reg     <= '0;
      start_lvl_reg <= 1'b0;
      state_reg     <= S_ACQ;
      cnt_reg       <= '0;
      gap_reg       <= '0;
      seen_reg      <= 1'b0;
      bip_reg       <= 1'b0;
      hold_reg      <= '0;
      result_reg    <= '0;
      valid_reg     <= 1'b0;
      rate_reg      <= 1'b0;
      pos_reg       <= '0;
      neg_reg       <= '0;
      src_reg       <= NEG_GND;
      mid_reg       <= 1'b0;
      bw_reg        <= 1'b0;
    end else begin
      cfg_reg       <= cfg_next;
      rdata_reg     <= rdata_next;
      start_lvl_reg <= start_lvl_next;
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      gap_reg       <= gap_next;
      seen_reg      <= seen_next;
      bip_reg       <= bip_next;
      hold_reg      <= hold_next;
      result_reg    <= result_next;
      valid_reg     <= valid_next;
      rate_reg      <= rate_next;
      pos_reg       <= pos_next;
      neg_reg       <= neg_next;
      src_reg       <= src_next;
      mid_reg       <= mid_next;
      bw_reg        <= bw_next;
    end
  end

  assign MUX_POS_CH        = pos_reg;
  assign MUX_NEG_CH        = neg_reg;
  assign MUX_NEG_SRC       = src_reg;
  assign NEG_BIAS_MID      = mid_reg;
  assign FILTER_QUARTER_BW = bw_reg;
  assign CONV_BUSY         = state_reg == S_CONV;
  assign RESULT_CODE       = result_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  localparam int CONV_LAST = CONV_CYCLES - 1;
  logic in_uni, in_bip, acq;
  assign in_uni = hold_reg >= 18'sh0_0000 && hold_reg <= 18'sh0_FFFF;
  assign in_bip = hold_reg >= -18'sh0_8000 && hold_reg <= 18'sh0_7FFF;
  assign acq    = state_reg == S_ACQ;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  property p_uni_code;
    done && !bip_reg && in_uni |=> RESULT_CODE == $past(hold_reg[15:0]);
  endproperty
  a_uni_code: assert property (p_uni_code)
    else $error("unipolar code is not straight binary");

  property p_bip_code;
    done && bip_reg && in_bip |=> RESULT_CODE == $past(hold_reg[15:0]);
  endproperty
  a_bip_code: assert property (p_bip_code)
    else $error("bipolar code is not twos complement");

  property p_top_clamp;
    done && hold_reg > 18'sh0_7FFF && (bip_reg || !in_uni) &&
      hold_reg > 18'sh0_0000
      |=> RESULT_CODE == ($past(bip_reg) ? BIP_TOP : UNI_TOP);
  endproperty
  a_top_clamp: assert property (p_top_clamp)
    else $error("overrange did not clamp to top code");

  property p_bot_clamp;
    done && ((!bip_reg && hold_reg < 18'sh0_0000) ||
             (bip_reg && !in_bip && hold_reg < 18'sh0_0000))
      |=> RESULT_CODE == ($past(bip_reg) ? BIP_BOT : UNI_BOT);
  endproperty
  a_bot_clamp: assert property (p_bot_clamp)
    else $error("underrange did not clamp to bottom code");

  property p_bw_pin;
    wr_cfg |=> ##1 FILTER_QUARTER_BW == $past(PWDATA[CFG_BW_BIT], 2);
  endproperty
  a_bw_pin: assert property (p_bw_pin)
    else $error("filter bandwidth pin does not follow configuration");

  property p_single;
    acq && mux.incc == INCC_SINGLE
      |-> mux.mode == MODE_SINGLE ##1 MUX_NEG_SRC == NEG_GND && !NEG_BIAS_MID;
  endproperty
  a_single: assert property (p_single)
    else $error("single-ended mode not referenced to ground");

  property p_common;
    acq && (mux.incc == INCC_COM_BIP || mux.incc == INCC_COM_UNI)
      |=> MUX_NEG_SRC == NEG_COM && NEG_BIAS_MID == !$past(mux.incc[2]);
  endproperty
  a_common: assert property (p_common)
    else $error("common input mode decoded wrongly");

  property p_pairs;
    acq && mux.incc[1] == 1'b0
      |=> MUX_NEG_SRC == NEG_PAIR && MUX_NEG_CH == (MUX_POS_CH ^ 3'b001)
          && NEG_BIAS_MID == !$past(mux.incc[2]);
  endproperty
  a_pairs: assert property (p_pairs)
    else $error("paired mode decoded wrongly");

  property p_pos_sel;
    acq && mux.incc[1] == 1'b0 |=>
      MUX_POS_CH == ($past(mux.seq_on) ? {$past(mux.inx[2:1]), 1'b0}
                                        : $past(mux.inx));
  endproperty
  a_pos_sel: assert property (p_pos_sel)
    else $error("pair positive input selection wrong");

  property p_conv_len;
    start_rise && acq |=> CONV_BUSY ##CONV_LAST CONV_BUSY ##1 !CONV_BUSY;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length is wrong");

  property p_range_latch;
    start_rise && acq |=> bip_reg == $past(mux.bipolar) ##1
      (CONV_BUSY && $stable(bip_reg)) [*7];
  endproperty
  a_range_latch: assert property (p_range_latch)
    else $error("conversion range not taken at start");

  property p_cfg_write;
    wr_cfg |=> cfg_reg == $past(PWDATA[13:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("configuration write not accepted");

  c_uni_done:  cover property (done && !bip_reg);
  c_bip_done:  cover property (done && bip_reg);
  c_clamp_top: cover property (done && !in_uni && !bip_reg);
  c_rate_err:  cover property ($rose(rate_reg));

endmodule : aicf_top

// File: include/aicf_pkg.sv
// Shared constants and types for the input configuration and code block.
package aicf_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned CONV_TIME_NS   = 2200;
  localparam int unsigned CONV_CYCLES    =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_PERIOD_NS  = 4000;
  localparam int unsigned QBW_GAP_CYCLES =
    (4 * MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W          = 10;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ADDR_CFG       = 8'h00;
  localparam logic [7:0]  ADDR_RESULT    = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;
  localparam int          CFG_W          = 14;
  localparam logic [13:0] CFG_RESET      = 14'h1C00;
  localparam int          CFG_INCC_LSB   = 10;
  localparam int          CFG_INX_LSB    = 7;
  localparam int          CFG_BW_BIT     = 6;
  localparam int          CFG_SEQ_LSB    = 1;
  localparam int          STAT_BUSY      = 0;
  localparam int          STAT_VALID     = 1;
  localparam int          STAT_BIPOLAR   = 2;
  localparam int          STAT_RATE_ERR  = 3;
  localparam int          STAT_POS_LSB   = 4;
  localparam int          STAT_NEG_LSB   = 7;
  localparam int          STAT_SRC_LSB   = 10;

  // ----------------------------------------------------------------------
  // Input configuration codes and result codes
  // ----------------------------------------------------------------------
  localparam logic [2:0]  INCC_SINGLE    = 3'b111;
  localparam logic [2:0]  INCC_COM_BIP   = 3'b010;
  localparam logic [2:0]  INCC_COM_UNI   = 3'b110;
  localparam logic [1:0]  INCC_PAIR_BIP  = 2'b00;
  localparam logic [1:0]  INCC_PAIR_UNI  = 2'b10;
  localparam int          DIFF_W         = 18;
  localparam logic [15:0] UNI_TOP        = 16'hFFFF;
  localparam logic [15:0] UNI_BOT        = 16'h0000;
  localparam logic [15:0] BIP_TOP        = 16'h7FFF;
  localparam logic [15:0] BIP_BOT        = 16'h8000;

  typedef enum logic [2:0] {
    MODE_SINGLE   = 3'b000,
    MODE_COM_BIP  = 3'b001,
    MODE_COM_UNI  = 3'b010,
    MODE_PAIR_BIP = 3'b011,
    MODE_PAIR_UNI = 3'b100
  } aicf_mode_t;

  typedef enum logic [1:0] {
    NEG_GND  = 2'b00,
    NEG_COM  = 2'b01,
    NEG_PAIR = 2'b10
  } aicf_neg_t;

  typedef enum logic [0:0] {
    S_ACQ  = 1'b0,
    S_CONV = 1'b1
  } aicf_state_t;

endpackage : aicf_pkg

// File: include/aicf_mux_if.sv
// Interface between the control top and the input mode decoder.
`timescale 1ns/1ps
interface aicf_mux_if;
  import aicf_pkg::*;
  logic [2:0] incc;
  logic [2:0] inx;
  logic       seq_on;
  aicf_mode_t mode;
  logic [2:0] pos_ch;
  logic [2:0] neg_ch;
  aicf_neg_t  neg_src;
  logic       bipolar;
  modport dec (input incc, inx, seq_on,
               output mode, pos_ch, neg_ch, neg_src, bipolar);
  modport ctl (output incc, inx, seq_on,
               input mode, pos_ch, neg_ch, neg_src, bipolar);
endinterface : aicf_mux_if

// File: src/aicf_mode_decode.sv
// Decodes the input configuration and channel fields into mux selections.
`timescale 1ns/1ps
module aicf_mode_decode (
  aicf_mux_if.dec m
);
  import aicf_pkg::*;

  always_comb begin
    logic paired;
    paired    = 1'b0;
    m.pos_ch  = m.inx;
    m.neg_ch  = 3'b000;
    m.neg_src = NEG_GND;
    m.bipolar = 1'b0;
    m.mode    = MODE_SINGLE;
    if (m.incc == INCC_COM_BIP) begin
      m.mode    = MODE_COM_BIP;
      m.neg_src = NEG_COM;
      m.bipolar = 1'b1;
    end else if (m.incc == INCC_COM_UNI) begin
      m.mode    = MODE_COM_UNI;
      m.neg_src = NEG_COM;
    end else if (m.incc[2:1] == INCC_PAIR_BIP) begin
      m.mode    = MODE_PAIR_BIP;
      m.bipolar = 1'b1;
      paired    = 1'b1;
    end else if (m.incc[2:1] == INCC_PAIR_UNI) begin
      m.mode    = MODE_PAIR_UNI;
      paired    = 1'b1;
    end
    // The unused 011 code falls back to single-ended ground reference.
    if (paired) begin
      m.neg_src = NEG_PAIR;
      // The sequencer only ever scans pairs with the even member positive.
      m.pos_ch  = m.seq_on ? {m.inx[2:1], 1'b0} : m.inx;
      m.neg_ch  = {m.pos_ch[2:1], ~m.pos_ch[0]};
    end
  end

endmodule : aicf_mode_decode

// File: src/aicf_code_format.sv
// Turns a signed input difference into a clamped 16-bit output code.
`timescale 1ns/1ps
module aicf_code_format (
  input  wire logic signed [17:0] diff,
  input  wire logic               bipolar,
  output logic             [15:0] code
);
  import aicf_pkg::*;

  localparam logic signed [17:0] UNI_MAX = 18'sh0_FFFF;
  localparam logic signed [17:0] BIP_MAX = 18'sh0_7FFF;
  localparam logic signed [17:0] BIP_MIN = -18'sh0_8000;

  always_comb begin
    // One step is the reference over 65536, so the low 16 bits are the code.
    code = diff[15:0];
    if (bipolar) begin
      if (diff > BIP_MAX) begin
        code = BIP_TOP;
      end else if (diff < BIP_MIN) begin
        code = BIP_BOT;
      end
    end else begin
      if (diff > UNI_MAX) begin
        code = UNI_TOP;
      end else if (diff < 18'sh0_0000) begin
        code = UNI_BOT;
      end
    end
  end

endmodule : aicf_code_format

// File: verif/aicf_host_model.sv
// APB host model that writes configuration words and reads results.
`timescale 1ns/1ps
module aicf_host_model (
  input  wire logic        SYS_CLK,
  output logic             PSEL,
  output logic             PENABLE,
  output logic             PWRITE,
  output logic [7:0]       PADDR,
  output logic [31:0]      PWDATA,
  input  wire logic [31:0] PRDATA,
  input  wire logic        PREADY,
  input  wire logic        PSLVERR
);
  initial begin
    PSEL    = 1'b0;
    PENABLE = 1'b0;
    PWRITE  = 1'b0;
    PADDR   = 8'h00;
    PWDATA  = 32'h0000_0000;
  end

  // Released address and data lines show the inverse of the last value.
  task automatic apb_xfer(input logic wr, input logic [7:0] addr,
                          input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic err);
    @(posedge SYS_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= addr;
    PWDATA  <= wdata;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    @(posedge SYS_CLK);
    while (PREADY !== 1'b1) @(posedge SYS_CLK);
    rdata   = PRDATA;
    err     = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    PADDR   <= ~addr;
    PWDATA  <= ~wdata;
  endtask : apb_xfer

  task automatic cfg_write(input logic [13:0] cfg);
    logic [31:0] rd;
    logic        er;
    apb_xfer(1'b1, 8'h00, {18'h0_0000, cfg}, rd, er);
  endtask : cfg_write
endmodule : aicf_host_model

// File: verif/aicf_top_bench.sv
// Self-checking bench for input configuration and output coding.
`timescale 1ns/1ps
module aicf_top_bench;
  import aicf_pkg::*;
  logic               SYS_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY;
  logic               PSLVERR, PIN, NEG_BIAS_MID, FILTER_QUARTER_BW;
  logic               CONV_BUSY, err;
  logic [7:0]         PADDR;
  logic [31:0]        PWDATA, PRDATA, rd;
  logic signed [17:0] RAW_DIFF;
  logic [2:0]         MUX_POS_CH, MUX_NEG_CH;
  aicf_neg_t          MUX_NEG_SRC;
  logic [15:0]        RESULT_CODE;
  int                 num_errors, n_tests;
  logic [2:0] mcode [7] = '{3'b111, 3'b010, 3'b110, 3'b000, 3'b001,
                            3'b100, 3'b101};
  logic [1:0] msrc  [7] = '{2'd0, 2'd1, 2'd1, 2'd2, 2'd2, 2'd2, 2'd2};
  logic       mbip  [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  int         diffs [4] = '{100, -40000, 70000, -5};

  aicf_top i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CONVERSION_START_PIN(PIN), .RAW_DIFF(RAW_DIFF),
    .MUX_POS_CH(MUX_POS_CH), .MUX_NEG_CH(MUX_NEG_CH),
    .MUX_NEG_SRC(MUX_NEG_SRC), .NEG_BIAS_MID(NEG_BIAS_MID),
    .FILTER_QUARTER_BW(FILTER_QUARTER_BW), .CONV_BUSY(CONV_BUSY),
    .RESULT_CODE(RESULT_CODE));
  aicf_host_model i_host (.SYS_CLK(SYS_CLK), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic [15:0] exp_code(input int d, input logic bip);
    if (bip) begin
      exp_code = d > 32767 ? 16'h7FFF : d < -32768 ? 16'h8000 : d[15:0];
    end else begin
      exp_code = d > 65535 ? 16'hFFFF : d < 0 ? 16'h0000 : d[15:0];
    end
  endfunction : exp_code

  function automatic logic [13:0] cfg(input logic [2:0] incc,
    input logic [2:0] ch, input logic bw, input logic [1:0] seq);
    cfg = {1'b0, incc, ch, bw, 3'b000, seq, 1'b0};
  endfunction : cfg

  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 200 && CONV_BUSY !== lvl; i++) @(negedge SYS_CLK);
    check({31'h0, CONV_BUSY}, {31'h0, lvl});
  endtask : wait_busy

  // The input is scrambled once the conversion is under way.
  task automatic conv_start(input int d);
    @(posedge SYS_CLK);
    RAW_DIFF <= 18'(d);
    PIN      <= 1'b1;
    wait_busy(1'b1);
    @(posedge SYS_CLK);
    PIN      <= 1'b0;
    RAW_DIFF <= ~RAW_DIFF;
  endtask : conv_start

  task automatic conv_end(input int d, input logic bip);
    wait_busy(1'b0);
    @(negedge SYS_CLK);
    check({16'h0, RESULT_CODE}, {16'h0, exp_code(d, bip)});
  endtask : conv_end

  task automatic set_cfg(input logic [13:0] c);
    i_host.cfg_write(c);
    repeat (2) @(negedge SYS_CLK);
  endtask : set_cfg

  initial begin
    repeat (20000) @(posedge SYS_CLK);
    num_errors++;
    complete_run();
  end

  initial begin
    RST_N    = 1'b0;
    PIN      = 1'b0;
    RAW_DIFF = 18'sd0;
    repeat (3) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    i_host.apb_xfer(1'b0, ADDR_CFG, 32'h0, rd, err);
    check(rd, {18'h0, CFG_RESET});
    i_host.apb_xfer(1'b0, 8'h0C, 32'h0, rd, err);
    check({rd[30:0], err}, 32'h0000_0001);
    $display("test reset_and_map done");
    for (int m = 0; m < 7; m++) begin
      set_cfg(cfg(mcode[m], 3'b000, 1'b0, 2'b00));
      check(32'(MUX_NEG_SRC), 32'(msrc[m]));
      check({31'h0, NEG_BIAS_MID}, {31'h0, mbip[m]});
      for (int k = 0; k < 4; k++) begin
        conv_start(diffs[k]);
        conv_end(diffs[k], mbip[m]);
      end
    end
    i_host.apb_xfer(1'b0, ADDR_RESULT, 32'h0, rd, err);
    check(rd, {16'h0, exp_code(-5, 1'b0)});
    i_host.apb_xfer(1'b0, ADDR_STATUS, 32'h0, rd, err);
    check({31'h0, rd[STAT_VALID]}, 32'h0);
    $display("test modes_and_codes done");
    set_cfg(cfg(3'b100, 3'b101, 1'b0, 2'b00));
    check({26'h0, MUX_POS_CH, MUX_NEG_CH}, {26'h0, 3'd5, 3'd4});
    set_cfg(cfg(3'b000, 3'b000, 1'b0, 2'b00));
    check({26'h0, MUX_POS_CH, MUX_NEG_CH}, {26'h0, 3'd0, 3'd1});
    set_cfg(cfg(3'b100, 3'b101, 1'b0, 2'b01));
    check({29'h0, MUX_POS_CH}, {29'h0, 3'd4});
    $display("test channel_pairs done");
    set_cfg(cfg(3'b010, 3'b000, 1'b0, 2'b00));
    conv_start(-5);
    i_host.cfg_write(cfg(3'b111, 3'b000, 1'b0, 2'b00));
    conv_end(-5, 1'b1);
    $display("test change_mid_conversion done");
    set_cfg(cfg(3'b111, 3'b000, 1'b1, 2'b00));
    check({31'h0, FILTER_QUARTER_BW}, 32'h1);
    conv_start(7);
    conv_end(7, 1'b0);
    conv_start(8);
    conv_end(8, 1'b0);
    i_host.apb_xfer(1'b0, ADDR_STATUS, 32'h0, rd, err);
    check({31'h0, rd[STAT_RATE_ERR]}, 32'h1);
    i_host.apb_xfer(1'b1, ADDR_STATUS, 32'h0000_0008, rd, err);
    i_host.apb_xfer(1'b0, ADDR_STATUS, 32'h0, rd, err);
    check({31'h0, rd[STAT_RATE_ERR]}, 32'h0);
    // A start spaced well beyond the quarter-rate gap must not flag.
    repeat (700) @(posedge SYS_CLK);
    conv_start(9);
    conv_end(9, 1'b0);
    i_host.apb_xfer(1'b0, ADDR_STATUS, 32'h0, rd, err);
    check({31'h0, rd[STAT_RATE_ERR]}, 32'h0);
    $display("test quarter_bandwidth done");
    complete_run();
  end
endmodule : aicf_top_bench
